/* hw/sadw_consts.vh */
`ifndef SADW_CONSTS_VH
`define SADW_CONSTS_VH

// ****************************************
// Clock and timing
// ****************************************
`define SADW_CLK_NS 100
`define SADW_TSTATE_NS 125
`define SADW_MEM_CYCLE_NS 500
`define SADW_TSTATES_PER_ACCESS 4
`define SADW_WAIT_BYTE_MEM 4
`define SADW_WAIT_WORD_MEM 12
`define SADW_WAIT_BYTE_IO 6
`define SADW_SYS_CLK_KHZ 8000
`define SADW_PERIPH_CLK_KHZ 4000

// ****************************************
// Memory map, 20-bit addresses
// ****************************************
`define SADW_RAM_TOP 20'h9_FFFF
`define SADW_RAM_SMALL_TOP 20'h7_FFFF
`define SADW_EXT_RAM_BASE 20'h8_0000
`define SADW_EXT_BLOCK_KB 32
`define SADW_VIDEO_BASE 20'hA_0000
`define SADW_DISPLAY_BASE 20'hB_0000
`define SADW_VIDEO_TOP 20'hB_FFFF
`define SADW_EXPROM_BASE 20'hC_0000
`define SADW_EXPROM_TOP 20'hE_FFFF
`define SADW_FWROM_WINDOW 20'hF_0000
`define SADW_FWROM_BASE 20'hF_C000
`define SADW_FWROM_TOP 20'hF_FFFF
`define SADW_FWROM_KB 16

// ****************************************
// I/O map, 10-bit decode
// ****************************************
`define SADW_IO_MASK 10'h3FF
`define SADW_DMA_LO 10'h000
`define SADW_DMA_HI 10'h00F
`define SADW_INTC_LO 10'h020
`define SADW_INTC_HI 10'h021
`define SADW_TMR_LO 10'h040
`define SADW_TMR_HI 10'h042
`define SADW_TMR_MODE 10'h043

`endif

/* hw/sadw_wait_counter.v */
`timescale 1ns/1ps
`default_nettype none

// Counts down a loaded number of clock cycles, one per clock.
module sadw_wait_counter #(
   parameter WIDTH = 8
) (
   input wire clk, // System clock.
   input wire sys_rst, // Asynchronous reset, active high.
   input wire load, // Load pulse.
   input wire [WIDTH-1:0] loadValue, // Cycles to count.
   output reg busy, // High while counting.
   output wire done // One-cycle pulse at the last count.
);

   reg [WIDTH-1:0] count;

   assign done = busy && (count == {{(WIDTH-1){1'b0}}, 1'b1});

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= {WIDTH{1'b0}};
         busy <= 1'b0;
      end else if (load) begin
         count <= loadValue;
         busy <= (loadValue != {WIDTH{1'b0}});
      end else if (busy) begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         if (done) begin
            busy <= 1'b0;
         end
      end
   end

endmodule // sadw_wait_counter

`default_nettype wire

/* hw/sadw_decode_wait.v */
`timescale 1ns/1ps
`default_nettype none
`include "sadw_consts.vh"

module sadw_decode_wait #(
   parameter REDUCED_RAM = 0,
   parameter EXT_RAM_BLOCKS = 0,
   parameter CLK_NS = `SADW_CLK_NS
) (
   input wire clk, // System clock, 10 MHz.
   input wire sys_rst, // Asynchronous reset, active high.
   input wire cycleStart, // One-cycle pulse: processor starts a bus cycle.
   input wire [19:0] cpuAddr, // Processor address.
   input wire isIo, // High for an I/O cycle.
   input wire isWrite, // High for a write cycle.
   input wire isWord, // High for a 16-bit transfer.
   input wire coprocBusy, // Coprocessor busy, active high.
   output wire cpuTest_n, // Processor test input, active low.
   output reg cpuReady, // One-cycle pulse: processor cycle complete.
   output reg periphClk, // Peripheral bus clock.
   output reg periphCycle, // High while a peripheral byte cycle runs.
   output reg periphByteHigh, // High during the high byte cycle.
   output reg selRam, // User RAM selected.
   output reg selExtRam, // External RAM range selected.
   output reg selDisplay, // Internal display adapter selected.
   output reg selFwRom, // Firmware ROM selected.
   output reg [13:0] fwRomAddr, // Firmware ROM offset.
   output reg parityEnable, // Parity generate and check enabled.
   output reg selDma, // DMA controller selected.
   output reg selIntc, // Interrupt controller selected.
   output reg selTimer, // Interval timer selected.
   output reg [1:0] timerReg, // Timer counter or mode register.
   output reg timerReadUndef // Read of timer mode register.
);

   // ****************************************
   // Timing counts
   // ****************************************
   localparam integer TSTATE_N = (`SADW_TSTATE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer MEM_N = (`SADW_MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam integer BYTE_MEM_N = MEM_N + `SADW_WAIT_BYTE_MEM * TSTATE_N;
   localparam integer HALF_WORD_N = MEM_N + (`SADW_WAIT_WORD_MEM / 2) * TSTATE_N;
   localparam integer BYTE_IO_N = MEM_N + `SADW_WAIT_BYTE_IO * TSTATE_N;
   localparam integer EXT_TOP_N = `SADW_EXT_RAM_BASE
      + EXT_RAM_BLOCKS * `SADW_EXT_BLOCK_KB * 1024 - 1;
   // The counts are cut to the width of the wait counter and the top to the address width.
   localparam [7:0] MEM_CYC = MEM_N[7:0];
   localparam [7:0] BYTE_MEM_CYC = BYTE_MEM_N[7:0];
   localparam [7:0] HALF_WORD_CYC = HALF_WORD_N[7:0];
   localparam [7:0] BYTE_IO_CYC = BYTE_IO_N[7:0];
   localparam [19:0] EXT_TOP = EXT_TOP_N[19:0];

   localparam ST_IDLE = 2'd0;
   localparam ST_FAST = 2'd1;
   localparam ST_LOW = 2'd2;
   localparam ST_HIGH = 2'd3;

   function inRange;
      input [19:0] a;
      input [19:0] lo;
      input [19:0] hi;
      begin
         inRange = (a >= lo) && (a <= hi);
      end
   endfunction

   reg [1:0] state;
   reg [1:0] next_state;
   reg periphDiv;
   reg isSlow;
   reg wordCycle;
   reg ioCycle;
   reg load;
   reg [7:0] loadValue;
   reg ramHit;
   reg extHit;
   reg [9:0] ioAddr;
   wire waitDone;

   assign cpuTest_n = ~coprocBusy;

   // ****************************************
   // Address decode
   // ****************************************
   always @* begin
      ioAddr = cpuAddr[9:0] & `SADW_IO_MASK;
      if (REDUCED_RAM != 0) begin
         ramHit = inRange(cpuAddr, 20'h0_0000, `SADW_RAM_SMALL_TOP);
         extHit = (EXT_RAM_BLOCKS != 0) && inRange(cpuAddr, `SADW_EXT_RAM_BASE, EXT_TOP);
      end else begin
         ramHit = inRange(cpuAddr, 20'h0_0000, `SADW_RAM_TOP);
         extHit = 1'b0;
      end
      // Only 8-bit targets are slow; expansion ROM space goes out on the peripheral bus.
      isSlow = isIo || extHit || inRange(cpuAddr, `SADW_EXPROM_BASE, `SADW_EXPROM_TOP);
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         selRam <= 1'b0;
         selExtRam <= 1'b0;
         selDisplay <= 1'b0;
         selFwRom <= 1'b0;
         fwRomAddr <= 14'h0000;
         parityEnable <= 1'b0;
         selDma <= 1'b0;
         selIntc <= 1'b0;
         selTimer <= 1'b0;
         timerReg <= 2'b00;
         timerReadUndef <= 1'b0;
      end else if (cycleStart && state == ST_IDLE) begin
         // A start offered while busy is ignored, so the selects keep describing the running cycle.
         selRam <= !isIo && ramHit;
         selExtRam <= !isIo && extHit;
         selDisplay <= !isIo && inRange(cpuAddr, `SADW_DISPLAY_BASE, `SADW_VIDEO_TOP);
         selFwRom <= !isIo && inRange(cpuAddr, `SADW_FWROM_WINDOW, `SADW_FWROM_TOP);
         fwRomAddr <= cpuAddr[13:0];
         parityEnable <= !isIo && ramHit;
         selDma <= isIo && inRange({10'h000, ioAddr}, {10'h000, `SADW_DMA_LO}, {10'h000, `SADW_DMA_HI});
         selIntc <= isIo && inRange({10'h000, ioAddr}, {10'h000, `SADW_INTC_LO}, {10'h000, `SADW_INTC_HI});
         selTimer <= isIo && inRange({10'h000, ioAddr}, {10'h000, `SADW_TMR_LO}, {10'h000, `SADW_TMR_MODE});
         timerReg <= ioAddr[1:0];
         timerReadUndef <= isIo && !isWrite && (ioAddr == `SADW_TMR_MODE);
      end else if (cpuReady) begin
         selRam <= 1'b0;
         selExtRam <= 1'b0;
         selDisplay <= 1'b0;
         selFwRom <= 1'b0;
         parityEnable <= 1'b0;
         selDma <= 1'b0;
         selIntc <= 1'b0;
         selTimer <= 1'b0;
         timerReadUndef <= 1'b0;
      end
   end

   // ****************************************
   // Peripheral clock, 2.5 MHz from two-clock T-states at 10 MHz
   // ****************************************
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         periphDiv <= 1'b0;
         periphClk <= 1'b0;
      end else begin
         // One T-state is two clocks, so the bus clock toggles every T-state.
         periphDiv <= ~periphDiv;
         if (periphDiv) begin
            periphClk <= ~periphClk;
         end
      end
   end

   // ****************************************
   // Cycle sequencer
   // ****************************************
   always @* begin
      next_state = state;
      load = 1'b0;
      loadValue = 8'h00;
      case (state)
         ST_IDLE: begin
            if (cycleStart) begin
               load = 1'b1;
               if (!isSlow) begin
                  loadValue = MEM_CYC;
                  next_state = ST_FAST;
               end else begin
                  loadValue = isIo ? BYTE_IO_CYC : (isWord ? HALF_WORD_CYC : BYTE_MEM_CYC);
                  next_state = ST_LOW;
               end
            end
         end
         ST_FAST: begin
            if (waitDone) begin
               next_state = ST_IDLE;
            end
         end
         ST_LOW: begin
            if (waitDone) begin
               if (wordCycle) begin
                  load = 1'b1;
                  loadValue = ioCycle ? BYTE_IO_CYC : HALF_WORD_CYC;
                  next_state = ST_HIGH;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_HIGH: begin
            if (waitDone) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         wordCycle <= 1'b0;
         ioCycle <= 1'b0;
         cpuReady <= 1'b0;
         periphCycle <= 1'b0;
         periphByteHigh <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_IDLE && cycleStart) begin
            wordCycle <= isWord && isSlow;
            ioCycle <= isIo;
         end
         // Ready only after the last byte cycle, so the processor never sees half a word.
         cpuReady <= waitDone && (state == ST_FAST || state == ST_HIGH
            || (state == ST_LOW && !wordCycle));
         periphCycle <= (next_state == ST_LOW) || (next_state == ST_HIGH);
         periphByteHigh <= (next_state == ST_HIGH);
      end
   end

   sadw_wait_counter #(
      .WIDTH(8)
   ) waitCounter (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(load),
      .loadValue(loadValue),
      .busy(),
      .done(waitDone)
   );

endmodule // sadw_decode_wait

`default_nettype wire

/* tb/sadw_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Processor side: one bus cycle per call.
// ****
module sadw_cpu_model (
   input wire logic clk, // Clock.
   input wire logic cpuReady, // Cycle done.
   output logic cycleStart, // Start pulse.
   output logic [19:0] cpuAddr, // Address.
   output logic isIo, // I/O cycle.
   output logic isWrite, // Write.
   output logic isWord // Word.
);
   initial begin
      cycleStart = 0;
      cpuAddr = 20'h0_0000;
      {isIo, isWrite, isWord} = 3'h0;
   end
   task run(input logic [19:0] a, input logic io, wr, wd, output int lat);
      // Released lines show a fresh pattern, never the old value.
      @(negedge clk);
      cpuAddr = ~cpuAddr;
      {isIo, isWrite, isWord} = ~{isIo, isWrite, isWord};
      @(negedge clk);
      cycleStart = 1;
      cpuAddr = a;
      {isIo, isWrite, isWord} = {io, wr, wd};
      @(negedge clk);
      cycleStart = 0;
      lat = 1;
      // Returns at the falling edge before the rising edge that samples ready, request still held.
      while (cpuReady !== 1'b1 && lat < 100) begin
         @(negedge clk);
         lat++;
      end
   endtask
endmodule // sadw_cpu_model
`default_nettype wire

/* tb/sadw_decode_wait_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sadw_decode_wait_monitor (
   input wire logic clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic cycleStart, // Start.
   input wire logic [19:0] cpuAddr, // Address.
   input wire logic isIo, // I/O.
   input wire logic isWord, // Word.
   input wire logic coprocBusy, // Busy in.
   input wire logic cpuTest_n, // Test out.
   input wire logic cpuReady, // Done.
   input wire logic periphClk, // Bus clock.
   input wire logic periphCycle, // Byte cycle.
   input wire logic periphByteHigh, // High byte.
   input wire logic selRam, // RAM.
   input wire logic selDisplay, // Display.
   input wire logic selFwRom, // ROM.
   input wire logic selExtRam, // Ext RAM.
   input wire logic parityEnable, // Parity.
   input wire logic selTimer // Timer.
);
   logic busy;
   wire take = cycleStart && !busy;
   wire slowMem = cpuAddr >= 20'hC_0000 && cpuAddr <= 20'hE_FFFF;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) busy <= 1'b0;
      else if (take) busy <= 1'b1;
      else if (cpuReady) busy <= 1'b0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_test; cpuTest_n == !coprocBusy; endproperty
   property p_fast; take && !isIo && !slowMem |-> !cpuReady [*6] ##1 cpuReady; endproperty
   property p_bmem; take && !isIo && !isWord && slowMem |-> ##14 cpuReady; endproperty
   property p_bio; take && isIo && !isWord |-> ##18 cpuReady; endproperty
   property p_word; take && isWord && (isIo || slowMem) |-> ##35 cpuReady; endproperty
   property p_half; take && isWord && isIo |=> periphCycle && !periphByteHigh ##20 periphByteHigh;
   endproperty
   property p_pclk; $changed(periphClk) |=> $stable(periphClk) ##1 $changed(periphClk); endproperty
   property p_ram; take && !isIo && cpuAddr <= 20'h9_FFFF |=> selRam && parityEnable; endproperty
   property p_rom; take && !isIo && cpuAddr >= 20'hF_0000 |=> selFwRom && !parityEnable; endproperty
   property p_exp; take && !isIo && slowMem |=> !(selRam || selDisplay || selFwRom || selExtRam);
   endproperty
   property p_io; take && isIo |=> selTimer == ($past(cpuAddr[9:2]) == 8'h10); endproperty
   a_test: assert property (p_test) else $error("test input wrong");
   a_fast: assert property (p_fast) else $error("fast cycle length");
   a_bmem: assert property (p_bmem) else $error("byte memory waits");
   a_bio: assert property (p_bio) else $error("byte io waits");
   a_word: assert property (p_word) else $error("word waits");
   a_half: assert property (p_half) else $error("byte order");
   a_pclk: assert property (p_pclk) else $error("bus clock period");
   a_ram: assert property (p_ram) else $error("ram select");
   a_rom: assert property (p_rom) else $error("rom select");
   a_exp: assert property (p_exp) else $error("expansion claimed");
   a_io: assert property (p_io) else $error("timer select");
   c_word: cover property (take && isWord && isIo);
   c_rom: cover property (take && !isIo && cpuAddr >= 20'hF_0000);
   c_bmem: cover property (take && !isIo && slowMem);
endmodule // sadw_decode_wait_monitor
bind sadw_decode_wait sadw_decode_wait_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
   .cycleStart(cycleStart), .cpuAddr(cpuAddr), .isIo(isIo), .isWord(isWord),
   .coprocBusy(coprocBusy), .cpuTest_n(cpuTest_n), .cpuReady(cpuReady), .periphClk(periphClk),
   .periphCycle(periphCycle), .periphByteHigh(periphByteHigh), .selRam(selRam),
   .selDisplay(selDisplay), .selFwRom(selFwRom), .selExtRam(selExtRam),
   .parityEnable(parityEnable), .selTimer(selTimer));
`default_nettype wire

/* tb/sadw_decode_wait_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sadw_decode_wait_test;
   logic clk = 0, sys_rst = 1, coprocBusy = 0;
   logic [31:0] rnd = 32'h5e84_5ede;
   int err_total = 0, tests_run = 0, lat, i, j;
   wire logic cycleStart, isIo, isWrite, isWord, cpuTest_n, cpuReady, selRam, selExtRam;
   wire logic selDisplay, selFwRom, parityEnable, selDma, selIntc, selTimer, timerReadUndef;
   wire logic [19:0] cpuAddr;
   wire logic [13:0] fwRomAddr;
   wire logic [1:0] timerReg;
   logic [19:0] mt [10] = '{20'h0_0000, 20'h9_FFFF, 20'hA_0000, 20'hB_0000, 20'hB_FFFF,
      20'hC_0000, 20'hE_FFFF, 20'hF_0000, 20'hF_C123, 20'hF_FFFF};
   logic [19:0] it [9] = '{20'h0_0000, 20'h0_000F, 20'h0_0010, 20'h0_0020, 20'h0_0021,
      20'h0_0022, 20'h0_0042, 20'h0_0043, 20'hF_FC40};
   always #50 clk = ~clk;
   always @(negedge clk) coprocBusy <= ~coprocBusy ^ rnd[7];
   sadw_cpu_model cpu (.clk(clk), .cpuReady(cpuReady), .cycleStart(cycleStart),
      .cpuAddr(cpuAddr), .isIo(isIo), .isWrite(isWrite), .isWord(isWord));
   sadw_decode_wait dut (.clk(clk), .sys_rst(sys_rst), .cycleStart(cycleStart),
      .cpuAddr(cpuAddr), .isIo(isIo), .isWrite(isWrite), .isWord(isWord),
      .coprocBusy(coprocBusy), .cpuTest_n(cpuTest_n), .cpuReady(cpuReady), .periphClk(),
      .periphCycle(), .periphByteHigh(), .selRam(selRam), .selExtRam(selExtRam),
      .selDisplay(selDisplay), .selFwRom(selFwRom), .fwRomAddr(fwRomAddr),
      .parityEnable(parityEnable), .selDma(selDma), .selIntc(selIntc), .selTimer(selTimer),
      .timerReg(timerReg), .timerReadUndef(timerReadUndef));
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input logic [19:0] a, input logic io, wr, wd);
      logic slow;
      logic [9:0] p;
      p = a[9:0];
      slow = io || (a >= 20'hC_0000 && a <= 20'hE_FFFF);
      cpu.run(a, io, wr, wd, lat);
      check(lat, !slow ? 6 : wd ? 35 : io ? 18 : 14);
      if (io) check({selDma, selIntc, selTimer, timerReadUndef, selRam}, {p <= 10'h00F,
         p == 10'h020 || p == 10'h021, p >= 10'h040 && p <= 10'h043, p == 10'h043 && !wr,
         1'b0});
      else check({selRam, parityEnable, selExtRam, selDisplay, selFwRom, selDma},
         {a <= 20'h9_FFFF, a <= 20'h9_FFFF, 1'b0, a >= 20'hB_0000 && a <= 20'hB_FFFF,
         a >= 20'hF_0000, 1'b0});
      if (!io && a >= 20'hF_0000) check(fwRomAddr, a[13:0]);
      if (io && p >= 10'h040 && p <= 10'h043) check(timerReg, p[1:0]);
      check(cpuTest_n, !coprocBusy);
   endtask
   task results;
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ****
   // Fixed maps, then random cycles.
   // ****
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk) sys_rst = 0;
      for (j = 0; j < 2; j++) begin
         for (i = 0; i < 10; i++) cyc(mt[i], 1'b0, 1'b0, j[0]);
         for (i = 0; i < 9; i++) cyc(it[i], 1'b1, j[0], 1'b0);
      end
      cyc(20'h0_0040, 1'b1, 1'b1, 1'b1);
      for (i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         cyc(rnd[19:0], rnd[20], rnd[21], rnd[22]);
      end
      results;
   end
   initial begin
      #3000000;
      err_total++;
      results;
   end
endmodule // sadw_decode_wait_test
`default_nettype wire
